// *** ipsa_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module ipsa_chk #(
  parameter int SID_W = 16
) (
  input wire logic clk, // clock
  input wire logic rst_b, // reset, low
  input wire logic in_ack, // ingress taken
  input wire logic int_ack, // unit taken
  input wire logic int_abort, // unit refused
  input wire logic int_write, // unit write
  input wire logic eg_valid, // egress valid
  input wire logic eg_ready, // egress ready
  input wire logic [1:0] eg_ic, // inner cache
  input wire logic [SID_W:0] eg_stream_ident, // stream
  input wire logic eg_bypass, // bypass
  input wire logic eg_inst, // inst
  input wire logic eg_ns, // ns
  input wire logic eg_internal // unit access
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_ack_once; in_ack |=> !in_ack; endproperty
  a_ack_once: assert property (p_ack_once) else $error("in_ack too long");
  property p_int_once; int_ack |=> !int_ack; endproperty
  a_int_once: assert property (p_int_once) else $error("int_ack too long");
  property p_abort_pair; int_abort |-> int_ack; endproperty
  a_abort_pair: assert property (p_abort_pair) else $error("abort without ack");
  property p_abort_read; int_abort |-> !int_write; endproperty
  a_abort_read: assert property (p_abort_read) else $error("write refused");
  property p_hold; eg_valid && !eg_ready |=> eg_valid && $stable(eg_ic) && $stable(eg_stream_ident);
  endproperty
  a_hold: assert property (p_hold) else $error("egress changed while stalled");
  property p_own_id;
    eg_valid && eg_internal |-> eg_stream_ident[SID_W] && eg_bypass && eg_ns && !eg_inst;
  endproperty
  a_own_id: assert property (p_own_id) else $error("unit access sideband wrong");
  property p_client_id; eg_valid && !eg_internal |-> !eg_stream_ident[SID_W]; endproperty
  a_client_id: assert property (p_client_id) else $error("client stream marked own");
  property p_take_out; in_ack |-> ##[1:40] eg_valid; endproperty
  a_take_out: assert property (p_take_out) else $error("ingress not forwarded");
  c_abort: cover property (int_abort);
  c_stall: cover property (eg_valid && !eg_ready);
  c_own: cover property (eg_valid && eg_internal);
endmodule // ipsa_chk
bind ipsa_port_attr ipsa_chk #(.SID_W(SID_W)) u_chk (.clk, .rst_b, .in_ack, .int_ack,
  .int_abort, .int_write, .eg_valid, .eg_ready, .eg_ic, .eg_stream_ident, .eg_bypass,
  .eg_inst, .eg_ns, .eg_internal);
`default_nettype wire

// *** ipsa_consts.svh ***
`ifndef IPSA_CONSTS_SVH
`define IPSA_CONSTS_SVH

// register byte offsets
`define IPSA_REG_CTRL 8'h00
`define IPSA_REG_TABLE_ATTR 8'h04
`define IPSA_REG_QUEUE_ATTR 8'h08
`define IPSA_REG_PCIE_BASE 8'h0C
`define IPSA_REG_PCIE_MASK 8'h10
`define IPSA_REG_OVR_INDEX 8'h14
`define IPSA_REG_OVR_DATA 8'h18
`define IPSA_REG_STATUS 8'h1C
`define IPSA_REG_MSI_IDENT 8'h20

// control bits
`define IPSA_CTRL_OVR_EN 0
`define IPSA_CTRL_PCIE_EN 1

// attribute register fields
`define IPSA_ATTR_IC 0
`define IPSA_ATTR_OC 2
`define IPSA_ATTR_SH 4
`define IPSA_ATTR_CMD_RA 6
`define IPSA_ATTR_EVTQ_WA 7
`define IPSA_ATTR_PGREQ_WA 8

// status fields
`define IPSA_STAT_FAULT 0
`define IPSA_STAT_BUSY 1
`define IPSA_STAT_KIND 4
`define IPSA_STAT_COUNT 16

// override entry fields
`define IPSA_OVR_INST_EN 0
`define IPSA_OVR_INST 1
`define IPSA_OVR_NS_EN 2
`define IPSA_OVR_NS 3
`define IPSA_OVR_CA_EN 4
`define IPSA_OVR_IC 5
`define IPSA_OVR_OC 7
`define IPSA_OVR_SH_EN 9
`define IPSA_OVR_SH 10
`define IPSA_OVR_AL_EN 12
`define IPSA_OVR_RA 13
`define IPSA_OVR_WA 14

// cacheability and shareability encodings
`define IPSA_CA_NC 2'h0
`define IPSA_CA_WB 2'h1
`define IPSA_CA_WT 2'h2
`define IPSA_SH_NSH 2'h0
`define IPSA_SH_OSH 2'h2
`define IPSA_SH_ISH 2'h3

// reset values
`define IPSA_RST_WORD 32'h0000_0000
`define IPSA_RST_TABLE_ATTR 32'h0000_0031
`define IPSA_RST_QUEUE_ATTR 32'h0000_01F5

`endif

// *** ipsa_far.sv ***
`timescale 1ns/1ps
`default_nettype none
module ipsa_far (
  input wire logic clk, // clock
  input wire logic slow, // accept one cycle in four
  input wire logic eg_valid, // egress request
  output logic eg_ready // accept
);
  logic [1:0] cnt_q = 2'h0;
  always_ff @(posedge clk) cnt_q <= cnt_q + 2'h1;
  // slow mode stalls the block so held payload is exercised
  assign eg_ready = eg_valid && (!slow || cnt_q == 2'h3);
endmodule // ipsa_far
`default_nettype wire

// *** ipsa_ovr_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
module ipsa_ovr_mem #(
  parameter int W = 16,
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic clk, // clock
  input wire logic rst_b, // sync reset, active low
  input wire logic we, // write strobe
  input wire logic [AW-1:0] waddr, // write index
  input wire logic [W-1:0] wdata, // write data
  input wire logic re, // read enable
  input wire logic [AW-1:0] raddr, // read index
  output logic [W-1:0] rdata // registered read data
);
  logic [W-1:0] mem_q [DEPTH];
  logic [W-1:0] rdata_q;
  logic [W-1:0] rdata_d;

  always_comb begin
    rdata_d = re ? mem_q[raddr] : rdata_q;
  end

  // entries hold no reset; software loads them before enabling overrides
  always_ff @(posedge clk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;
endmodule // ipsa_ovr_mem
`default_nettype wire

// *** ipsa_pkg.sv ***
package ipsa_pkg;

  typedef enum logic [3:0] {
    IPSA_K_STREAM_FETCH = 4'h0,
    IPSA_K_VMS_FETCH = 4'h1,
    IPSA_K_CTX_FETCH = 4'h2,
    IPSA_K_S1_WALK = 4'h3,
    IPSA_K_S2_WALK = 4'h4,
    IPSA_K_CMD_FETCH = 4'h5,
    IPSA_K_EVTQ_WRITE = 4'h6,
    IPSA_K_PGREQ_WRITE = 4'h7,
    IPSA_K_MSI = 4'h8
  } ipsa_kind_t;

  typedef logic [1:0] ipsa_attr2_t;

endpackage

// *** ipsa_port_attr.sv ***
// Decided for this implementation: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ipsa_consts.svh"
module ipsa_port_attr
  import ipsa_pkg::*;
#(
  parameter int ADDR_W = 48,
  parameter int DATA_W = 64,
  parameter int SID_W = 16,
  parameter int SSID_W = 20,
  parameter int OVR_AW = 6,
  parameter bit SEC_SUPPORT = 1'b1
) (
  input wire logic clk, // 40 MHz clock
  input wire logic rst_b, // sync reset, active low
  input wire logic in_valid, // ingress request
  output logic in_ack, // ingress taken, one-cycle pulse
  input wire logic [ADDR_W-1:0] in_addr, // ingress address
  input wire logic in_write, // ingress direction
  input wire logic [DATA_W-1:0] in_wdata, // ingress write data
  input wire logic [SID_W-1:0] in_stream_ident, // client stream
  input wire logic [SSID_W-1:0] in_substream_ident, // substream
  input wire logic in_substream_valid, // substream present
  input wire logic in_security_state_tag, // 1 = secure stream
  input wire logic in_translated, // 1 = already translated
  input wire logic in_inst, // instruction hint
  input wire logic in_ns, // non-secure hint
  input wire logic [1:0] in_ic, // inner cacheability hint
  input wire logic [1:0] in_oc, // outer cacheability hint
  input wire logic [1:0] in_sh, // shareability hint
  input wire logic in_ra, // read-allocate hint
  input wire logic in_wa, // write-allocate hint
  input wire logic int_valid, // unit-originated request
  output logic int_ack, // request taken, one-cycle pulse
  output logic int_abort, // request ended with abort, pulse
  input wire logic [3:0] int_kind, // access kind
  input wire logic [ADDR_W-1:0] int_addr, // access address
  input wire logic int_write, // access direction
  input wire logic [DATA_W-1:0] int_wdata, // access write data
  input wire logic int_spec, // speculative access
  input wire logic [1:0] int_cfg_ic, // configured inner cacheability
  input wire logic [1:0] int_cfg_oc, // configured outer cacheability
  input wire logic [1:0] int_cfg_sh, // configured shareability
  input wire logic int_s2_en, // stage 2 enabled
  input wire logic [1:0] int_s2_ic, // stage 2 inner cacheability
  input wire logic [1:0] int_s2_oc, // stage 2 outer cacheability
  input wire logic [1:0] int_s2_sh, // stage 2 shareability
  input wire logic int_stage2_forced_writeback, // stage2_forced_writeback
  input wire logic int_stage2_walk_protect, // stage2_walk_protect
  output logic eg_valid, // egress request
  input wire logic eg_ready, // interconnect accepts
  output logic [ADDR_W-1:0] eg_addr, // egress address
  output logic eg_write, // egress direction
  output logic [DATA_W-1:0] eg_wdata, // egress write data
  output logic [SID_W:0] eg_stream_ident, // msb set = unit's own
  output logic [SSID_W-1:0] eg_substream_ident, // substream
  output logic eg_substream_valid, // substream present
  output logic eg_secure, // secure stream
  output logic eg_bypass, // translation bypassed
  output logic eg_inst, // instruction attribute
  output logic eg_ns, // non-secure attribute
  output logic [1:0] eg_ic, // inner cacheability
  output logic [1:0] eg_oc, // outer cacheability
  output logic [1:0] eg_sh, // shareability
  output logic eg_ra, // read-allocate
  output logic eg_wa, // write-allocate
  output logic eg_internal, // access originated by the unit
  input wire logic [7:0] avs_address, // byte address
  input wire logic avs_read, // read strobe
  input wire logic avs_write, // write strobe
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest // stall
);
  localparam int OVR_W = 16;

  function automatic logic [1:0] ca_comb(input logic [1:0] a, input logic [1:0] b);
    if (a == `IPSA_CA_NC || b == `IPSA_CA_NC) begin
      return `IPSA_CA_NC;
    end else if (a == `IPSA_CA_WT || b == `IPSA_CA_WT) begin
      return `IPSA_CA_WT;
    end
    return a;
  endfunction

  function automatic logic [1:0] sh_comb(input logic [1:0] a, input logic [1:0] b);
    if (a == `IPSA_SH_OSH || b == `IPSA_SH_OSH) begin
      return `IPSA_SH_OSH;
    end else if (a == `IPSA_SH_ISH || b == `IPSA_SH_ISH) begin
      return `IPSA_SH_ISH;
    end
    return `IPSA_SH_NSH;
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // register file
  logic [31:0] ctrl_q, ctrl_d, tattr_q, tattr_d, qattr_q, qattr_d;
  logic [31:0] pbase_q, pbase_d, pmask_q, pmask_d;
  logic [OVR_AW-1:0] oidx_q, oidx_d;
  logic [OVR_W-1:0] odata_q, odata_d;
  logic [SID_W-1:0] msi_q, msi_d;
  logic fault_q, fault_d;
  logic [3:0] fkind_q, fkind_d;
  logic [15:0] count_q, count_d;
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic mem_we;

  // request pipeline
  logic in_ack_q, in_ack_d, int_ack_q, int_ack_d, abort_q, abort_d;
  logic s1_v_q, s1_v_d, s1_int_q, s1_int_d;
  logic [ADDR_W-1:0] s1_addr_q, s1_addr_d, eg_addr_q, eg_addr_d;
  logic s1_wr_q, s1_wr_d, eg_wr_q, eg_wr_d;
  logic [DATA_W-1:0] s1_wdata_q, s1_wdata_d, eg_wdata_q, eg_wdata_d;
  logic [SID_W:0] s1_sid_q, s1_sid_d, eg_sid_q, eg_sid_d;
  logic [SSID_W-1:0] s1_ssid_q, s1_ssid_d, eg_ssid_q, eg_ssid_d;
  logic s1_ssv_q, s1_ssv_d, s1_sec_q, s1_sec_d, s1_byp_q, s1_byp_d;
  logic s1_inst_q, s1_inst_d, s1_ns_q, s1_ns_d, s1_ra_q, s1_ra_d, s1_wa_q, s1_wa_d;
  logic [1:0] s1_ic_q, s1_ic_d, s1_oc_q, s1_oc_d, s1_sh_q, s1_sh_d;
  logic eg_v_q, eg_v_d, eg_ssv_q, eg_ssv_d, eg_sec_q, eg_sec_d, eg_byp_q, eg_byp_d;
  logic eg_inst_q, eg_inst_d, eg_ns_q, eg_ns_d, eg_ra_q, eg_ra_d, eg_wa_q, eg_wa_d;
  logic eg_int_q, eg_int_d;
  logic [1:0] eg_ic_q, eg_ic_d, eg_oc_q, eg_oc_d, eg_sh_q, eg_sh_d;
  logic [OVR_W-1:0] ovr;
  logic s1_leave, slot_free, take_int, take_in, pcie_hit, ovr_en;
  logic [1:0] s2_ic, s2_oc;

  ipsa_ovr_mem #(.W(OVR_W), .DEPTH(1 << OVR_AW), .AW(OVR_AW)) u_ovr (
    .clk(clk),
    .rst_b(rst_b),
    .we(mem_we),
    .waddr(oidx_q),
    .wdata(avs_writedata[OVR_W-1:0]),
    .re(take_in),
    .raddr(in_stream_ident[OVR_AW-1:0]),
    .rdata(ovr)
  );

  // software bus: one wait cycle, then the access completes
  always_comb begin
    logic req;
    logic done;
    req = avs_read || avs_write;
    done = req && !wait_q;
    wait_d = !(req && wait_q);
    ctrl_d = ctrl_q;
    tattr_d = tattr_q;
    qattr_d = qattr_q;
    pbase_d = pbase_q;
    pmask_d = pmask_q;
    oidx_d = oidx_q;
    odata_d = odata_q;
    msi_d = msi_q;
    mem_we = 1'b0;
    fault_d = fault_q;
    fkind_d = fkind_q;
    rdata_d = rdata_q;
    if (done && avs_write) begin
      case (avs_address)
        `IPSA_REG_CTRL: ctrl_d = be_merge(ctrl_q, avs_writedata, avs_byteenable);
        `IPSA_REG_TABLE_ATTR: tattr_d = be_merge(tattr_q, avs_writedata, avs_byteenable);
        `IPSA_REG_QUEUE_ATTR: qattr_d = be_merge(qattr_q, avs_writedata, avs_byteenable);
        `IPSA_REG_PCIE_BASE: pbase_d = be_merge(pbase_q, avs_writedata, avs_byteenable);
        `IPSA_REG_PCIE_MASK: pmask_d = be_merge(pmask_q, avs_writedata, avs_byteenable);
        `IPSA_REG_OVR_INDEX: oidx_d = avs_writedata[OVR_AW-1:0];
        `IPSA_REG_OVR_DATA: begin
          mem_we = 1'b1;
          odata_d = avs_writedata[OVR_W-1:0];
        end
        `IPSA_REG_STATUS: begin
          if (avs_writedata[`IPSA_STAT_FAULT]) begin
            fault_d = 1'b0;
          end
        end
        `IPSA_REG_MSI_IDENT: msi_d = avs_writedata[SID_W-1:0];
        default: ;
      endcase
    end
    // a fault in the clearing cycle still lands
    if (abort_d && !int_spec) begin
      fault_d = 1'b1;
      fkind_d = int_kind;
    end
    if (req && wait_q) begin
      rdata_d = '0;
      case (avs_address)
        `IPSA_REG_CTRL: rdata_d = ctrl_q;
        `IPSA_REG_TABLE_ATTR: rdata_d = tattr_q;
        `IPSA_REG_QUEUE_ATTR: rdata_d = qattr_q;
        `IPSA_REG_PCIE_BASE: rdata_d = pbase_q;
        `IPSA_REG_PCIE_MASK: rdata_d = pmask_q;
        `IPSA_REG_OVR_INDEX: rdata_d[OVR_AW-1:0] = oidx_q;
        `IPSA_REG_OVR_DATA: rdata_d[OVR_W-1:0] = odata_q;
        `IPSA_REG_STATUS: begin
          rdata_d[`IPSA_STAT_FAULT] = fault_q;
          rdata_d[`IPSA_STAT_BUSY] = s1_v_q || eg_v_q;
          rdata_d[`IPSA_STAT_KIND +: 4] = fkind_q;
          rdata_d[`IPSA_STAT_COUNT +: 16] = count_q;
        end
        `IPSA_REG_MSI_IDENT: rdata_d[SID_W-1:0] = msi_q;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wait_q <= 1'b1;
      ctrl_q <= `IPSA_RST_WORD;
      tattr_q <= `IPSA_RST_TABLE_ATTR;
      qattr_q <= `IPSA_RST_QUEUE_ATTR;
      pbase_q <= `IPSA_RST_WORD;
      pmask_q <= `IPSA_RST_WORD;
      oidx_q <= '0;
      odata_q <= '0;
      msi_q <= '0;
      fault_q <= 1'b0;
      fkind_q <= '0;
      rdata_q <= `IPSA_RST_WORD;
    end else begin
      wait_q <= wait_d;
      ctrl_q <= ctrl_d;
      tattr_q <= tattr_d;
      qattr_q <= qattr_d;
      pbase_q <= pbase_d;
      pmask_q <= pmask_d;
      oidx_q <= oidx_d;
      odata_q <= odata_d;
      msi_q <= msi_d;
      fault_q <= fault_d;
      fkind_q <= fkind_d;
      rdata_q <= rdata_d;
    end
  end

  // unit requests win arbitration so queue writes cannot be starved by clients
  always_comb begin
    s1_leave = s1_v_q && (!eg_v_q || eg_ready);
    slot_free = !s1_v_q || s1_leave;
    take_int = int_valid && !int_ack_q && slot_free;
    take_in = in_valid && !in_ack_q && slot_free && !take_int;
    // only the low 32 address bits are matched against the window
    pcie_hit = ctrl_q[`IPSA_CTRL_PCIE_EN] && !int_write &&
               ((int_addr[31:0] & pmask_q) == pbase_q);
    ovr_en = ctrl_q[`IPSA_CTRL_OVR_EN];
    s2_ic = int_stage2_forced_writeback ? `IPSA_CA_WB : int_s2_ic;
    s2_oc = int_stage2_forced_writeback ? `IPSA_CA_WB : int_s2_oc;
    in_ack_d = take_in;
    int_ack_d = take_int;
    abort_d = take_int && pcie_hit;
    s1_v_d = s1_v_q && !s1_leave;
    s1_int_d = s1_int_q;
    s1_addr_d = s1_addr_q;
    s1_wr_d = s1_wr_q;
    s1_wdata_d = s1_wdata_q;
    s1_sid_d = s1_sid_q;
    s1_ssid_d = s1_ssid_q;
    s1_ssv_d = s1_ssv_q;
    s1_sec_d = s1_sec_q;
    s1_byp_d = s1_byp_q;
    s1_inst_d = s1_inst_q;
    s1_ns_d = s1_ns_q;
    s1_ic_d = s1_ic_q;
    s1_oc_d = s1_oc_q;
    s1_sh_d = s1_sh_q;
    s1_ra_d = s1_ra_q;
    s1_wa_d = s1_wa_q;
    if (take_int && !pcie_hit) begin
      s1_v_d = 1'b1;
      s1_int_d = 1'b1;
      s1_addr_d = int_addr;
      s1_wr_d = int_write;
      s1_wdata_d = int_wdata;
      s1_sid_d = {1'b1, msi_q};
      s1_ssid_d = '0;
      s1_ssv_d = 1'b0;
      s1_sec_d = 1'b0;
      s1_byp_d = 1'b1;
      s1_inst_d = 1'b0;
      s1_ns_d = 1'b1;
      s1_ic_d = int_cfg_ic;
      s1_oc_d = int_cfg_oc;
      s1_sh_d = int_cfg_sh;
      s1_ra_d = 1'b0;
      s1_wa_d = 1'b0;
      case (int_kind)
        IPSA_K_STREAM_FETCH, IPSA_K_VMS_FETCH: begin
          s1_ic_d = tattr_q[`IPSA_ATTR_IC +: 2];
          s1_oc_d = tattr_q[`IPSA_ATTR_OC +: 2];
          s1_sh_d = tattr_q[`IPSA_ATTR_SH +: 2];
        end
        IPSA_K_CTX_FETCH, IPSA_K_S1_WALK: begin
          if (int_s2_en) begin
            s1_ic_d = ca_comb(int_cfg_ic, s2_ic);
            s1_oc_d = ca_comb(int_cfg_oc, s2_oc);
            s1_sh_d = int_stage2_walk_protect ? `IPSA_SH_OSH : sh_comb(int_cfg_sh, int_s2_sh);
          end
        end
        IPSA_K_CMD_FETCH, IPSA_K_EVTQ_WRITE, IPSA_K_PGREQ_WRITE: begin
          s1_ic_d = qattr_q[`IPSA_ATTR_IC +: 2];
          s1_oc_d = qattr_q[`IPSA_ATTR_OC +: 2];
          s1_sh_d = qattr_q[`IPSA_ATTR_SH +: 2];
          s1_ra_d = (int_kind == IPSA_K_CMD_FETCH) && qattr_q[`IPSA_ATTR_CMD_RA];
          s1_wa_d = (int_kind == IPSA_K_EVTQ_WRITE) ? qattr_q[`IPSA_ATTR_EVTQ_WA] :
                    (int_kind == IPSA_K_PGREQ_WRITE) && qattr_q[`IPSA_ATTR_PGREQ_WA];
        end
        default: ;
      endcase
    end else if (take_in) begin
      s1_v_d = 1'b1;
      s1_int_d = 1'b0;
      s1_addr_d = in_addr;
      s1_wr_d = in_write;
      s1_wdata_d = in_wdata;
      s1_sid_d = {1'b0, in_stream_ident};
      s1_ssid_d = in_substream_ident;
      s1_ssv_d = in_substream_valid;
      s1_sec_d = SEC_SUPPORT && in_security_state_tag;
      s1_byp_d = in_translated;
      s1_inst_d = in_inst;
      s1_ns_d = in_ns;
      s1_ic_d = in_ic;
      s1_oc_d = in_oc;
      s1_sh_d = in_sh;
      s1_ra_d = in_ra;
      s1_wa_d = in_wa;
    end
  end

  // egress stage: override table entry arrives with the stage 1 slot
  always_comb begin
    logic use_ovr;
    use_ovr = ovr_en && !s1_int_q;
    eg_v_d = eg_v_q && !eg_ready;
    eg_addr_d = eg_addr_q;
    eg_wr_d = eg_wr_q;
    eg_wdata_d = eg_wdata_q;
    eg_sid_d = eg_sid_q;
    eg_ssid_d = eg_ssid_q;
    eg_ssv_d = eg_ssv_q;
    eg_sec_d = eg_sec_q;
    eg_byp_d = eg_byp_q;
    eg_inst_d = eg_inst_q;
    eg_ns_d = eg_ns_q;
    eg_ic_d = eg_ic_q;
    eg_oc_d = eg_oc_q;
    eg_sh_d = eg_sh_q;
    eg_ra_d = eg_ra_q;
    eg_wa_d = eg_wa_q;
    eg_int_d = eg_int_q;
    count_d = count_q;
    if (s1_leave) begin
      eg_v_d = 1'b1;
      count_d = count_q + 16'h0001;
      eg_addr_d = s1_addr_q;
      eg_wr_d = s1_wr_q;
      eg_wdata_d = s1_wdata_q;
      eg_sid_d = s1_sid_q;
      eg_ssid_d = s1_ssid_q;
      eg_ssv_d = s1_ssv_q;
      eg_sec_d = s1_sec_q;
      eg_byp_d = s1_byp_q;
      eg_int_d = s1_int_q;
      eg_inst_d = (use_ovr && ovr[`IPSA_OVR_INST_EN]) ? ovr[`IPSA_OVR_INST] : s1_inst_q;
      eg_ns_d = (use_ovr && ovr[`IPSA_OVR_NS_EN]) ? ovr[`IPSA_OVR_NS] : s1_ns_q;
      eg_ic_d = (use_ovr && ovr[`IPSA_OVR_CA_EN]) ? ovr[`IPSA_OVR_IC +: 2] : s1_ic_q;
      eg_oc_d = (use_ovr && ovr[`IPSA_OVR_CA_EN]) ? ovr[`IPSA_OVR_OC +: 2] : s1_oc_q;
      eg_sh_d = (use_ovr && ovr[`IPSA_OVR_SH_EN]) ? ovr[`IPSA_OVR_SH +: 2] : s1_sh_q;
      eg_ra_d = (use_ovr && ovr[`IPSA_OVR_AL_EN]) ? ovr[`IPSA_OVR_RA] : s1_ra_q;
      eg_wa_d = (use_ovr && ovr[`IPSA_OVR_AL_EN]) ? ovr[`IPSA_OVR_WA] : s1_wa_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      in_ack_q <= 1'b0;
      int_ack_q <= 1'b0;
      abort_q <= 1'b0;
      s1_v_q <= 1'b0;
      eg_v_q <= 1'b0;
      count_q <= '0;
    end else begin
      in_ack_q <= in_ack_d;
      int_ack_q <= int_ack_d;
      abort_q <= abort_d;
      s1_v_q <= s1_v_d;
      eg_v_q <= eg_v_d;
      count_q <= count_d;
    end
  end

  // stage 1 datapath flops need no reset; s1_v_q qualifies them
  always_ff @(posedge clk) begin
    s1_int_q <= s1_int_d;
    s1_addr_q <= s1_addr_d;
    s1_wr_q <= s1_wr_d;
    s1_wdata_q <= s1_wdata_d;
    s1_sid_q <= s1_sid_d;
    s1_ssid_q <= s1_ssid_d;
    s1_ssv_q <= s1_ssv_d;
    s1_sec_q <= s1_sec_d;
    s1_byp_q <= s1_byp_d;
    s1_inst_q <= s1_inst_d;
    s1_ns_q <= s1_ns_d;
    s1_ic_q <= s1_ic_d;
    s1_oc_q <= s1_oc_d;
    s1_sh_q <= s1_sh_d;
    s1_ra_q <= s1_ra_d;
    s1_wa_q <= s1_wa_d;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      eg_addr_q <= '0;
      eg_wr_q <= 1'b0;
      eg_wdata_q <= '0;
      eg_sid_q <= '0;
      eg_ssid_q <= '0;
      {eg_ssv_q, eg_sec_q, eg_byp_q, eg_inst_q, eg_ns_q, eg_ra_q, eg_wa_q, eg_int_q} <= 8'h00;
      {eg_ic_q, eg_oc_q, eg_sh_q} <= 6'h00;
    end else begin
      eg_addr_q <= eg_addr_d;
      eg_wr_q <= eg_wr_d;
      eg_wdata_q <= eg_wdata_d;
      eg_sid_q <= eg_sid_d;
      eg_ssid_q <= eg_ssid_d;
      {eg_ssv_q, eg_sec_q, eg_byp_q, eg_inst_q} <= {eg_ssv_d, eg_sec_d, eg_byp_d, eg_inst_d};
      {eg_ns_q, eg_ra_q, eg_wa_q, eg_int_q} <= {eg_ns_d, eg_ra_d, eg_wa_d, eg_int_d};
      {eg_ic_q, eg_oc_q, eg_sh_q} <= {eg_ic_d, eg_oc_d, eg_sh_d};
    end
  end

  assign in_ack = in_ack_q;
  assign int_ack = int_ack_q;
  assign int_abort = abort_q;
  assign eg_valid = eg_v_q;
  assign eg_addr = eg_addr_q;
  assign eg_write = eg_wr_q;
  assign eg_wdata = eg_wdata_q;
  assign eg_stream_ident = eg_sid_q;
  assign eg_substream_ident = eg_ssid_q;
  assign eg_substream_valid = eg_ssv_q;
  assign eg_secure = eg_sec_q;
  assign eg_bypass = eg_byp_q;
  assign eg_inst = eg_inst_q;
  assign eg_ns = eg_ns_q;
  assign eg_ic = eg_ic_q;
  assign eg_oc = eg_oc_q;
  assign eg_sh = eg_sh_q;
  assign eg_ra = eg_ra_q;
  assign eg_wa = eg_wa_q;
  assign eg_internal = eg_int_q;
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
endmodule // ipsa_port_attr
`default_nettype wire

// *** ipsa_port_attr_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ipsa_consts.svh"
module ipsa_port_attr_tb;
  localparam logic [63:0] KTAB = 64'h5D5D_5EA8_A8A8_4C4C;
  logic clk = 1'b0, rst_b = 1'b0, slow = 1'b0, ab;
  logic in_valid = '0, in_write = '0, in_substream_valid = '0, in_security_state_tag = '0;
  logic in_translated = '0, in_inst = '0, in_ns = '0, in_ra = '0, in_wa = '0;
  logic int_valid = '0, int_write = '0, int_spec = '0, int_s2_en = '0, int_stage2_forced_writeback = '0;
  logic int_stage2_walk_protect = '0, avs_read = '0, avs_write = '0;
  logic [1:0] in_ic = '0, in_oc = '0, in_sh = '0, int_cfg_ic = '0, int_cfg_oc = '0;
  logic [1:0] int_cfg_sh = '0, int_s2_ic = '0, int_s2_oc = '0, int_s2_sh = '0;
  logic [3:0] int_kind = '0, avs_byteenable = 4'hF;
  logic [7:0] avs_address = '0;
  logic [15:0] in_stream_ident = '0;
  logic [19:0] in_substream_ident = '0, eg_substream_ident;
  logic [31:0] avs_writedata = '0, rd, avs_readdata;
  logic [47:0] in_addr = '0, int_addr = '0, eg_addr;
  logic [63:0] in_wdata = '0, int_wdata = '0, eg_wdata;
  logic in_ack, int_ack, int_abort, eg_valid, eg_ready, eg_write, eg_substream_valid, eg_secure;
  logic eg_bypass, eg_inst, eg_ns, eg_ra, eg_wa, eg_internal, avs_waitrequest;
  logic [1:0] eg_ic, eg_oc, eg_sh;
  logic [16:0] eg_stream_ident;
  logic [27:0] cap, side;
  int n_mismatch = 0, samples_checked = 0, cyc = 0;
  ipsa_port_attr u_dut (.*);
  ipsa_far u_far (.clk(clk), .slow(slow), .eg_valid(eg_valid), .eg_ready(eg_ready));
  initial forever #12.5 clk = ~clk;
  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic chk(string nm, logic [27:0] got, logic [27:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic egw;
    do @(posedge clk); while (!(eg_valid === 1'b1 && eg_ready === 1'b1));
    cap = {eg_stream_ident, eg_bypass, eg_inst, eg_ns, eg_ic, eg_oc, eg_sh, eg_ra, eg_wa};
    side = {eg_substream_valid, eg_secure, eg_internal, eg_write, eg_substream_ident[7:0],
            eg_addr[15:8], eg_wdata[15:8]};
  endtask
  task automatic cli(logic [15:0] s, logic tr, logic [9:0] h);
    @(posedge clk);
    in_stream_ident <= s;
    in_addr <= {24'h0, s, 8'h0};
    in_wdata <= {40'h0, s, 8'h0};
    in_write <= tr;
    in_security_state_tag <= tr;
    in_substream_ident <= {4'h0, s};
    in_substream_valid <= tr;
    in_translated <= tr;
    {in_inst, in_ns, in_ic, in_oc, in_sh, in_ra, in_wa} <= h;
    in_valid <= 1'b1;
    do @(posedge clk); while (in_ack !== 1'b1);
    in_valid <= 1'b0;
    egw();
  endtask
  // c packs stage 2 enable, forced write-back, walk protect, then configured and stage 2 attrs
  task automatic req(logic [3:0] k, logic [31:0] a, logic sp, logic [14:0] c);
    @(posedge clk);
    int_kind <= k;
    int_addr <= {16'h0, a};
    int_wdata <= {32'h0, a};
    int_write <= k > 4'h5;
    int_spec <= sp;
    {int_s2_en, int_stage2_forced_writeback, int_stage2_walk_protect, int_cfg_ic, int_cfg_oc, int_cfg_sh} <= c[14:6];
    {int_s2_ic, int_s2_oc, int_s2_sh} <= c[5:0];
    int_valid <= 1'b1;
    do @(posedge clk); while (int_ack !== 1'b1);
    ab = int_abort;
    int_valid <= 1'b0;
    if (ab !== 1'b1) egw();
  endtask
  task automatic t_regs;
    bus(1'b0, `IPSA_REG_TABLE_ATTR, 32'h0);
    chk("table_attr", rd[27:0], 28'h31);
    bus(1'b0, `IPSA_REG_QUEUE_ATTR, 32'h0);
    chk("queue_attr", rd[27:0], 28'h1F5);
    bus(1'b1, 8'hFC, 32'hFFFF_FFFF);
    bus(1'b0, 8'hFC, 32'h0);
    chk("unmapped", rd[27:0], 28'h0);
  endtask
  task automatic t_client;
    slow <= 1'b1;
    cli(16'h0005, 1'b1, 10'h39E);
    chk("client", cap, {1'b0, 16'h0005, 1'b1, 10'h39E});
    chk("client_side", side, 28'hD050505);
    slow <= 1'b0;
  endtask
  task automatic t_override;
    bus(1'b1, `IPSA_REG_OVR_INDEX, 32'h5);
    bus(1'b1, `IPSA_REG_OVR_DATA, 32'h10);
    bus(1'b1, `IPSA_REG_CTRL, 32'h1);
    cli(16'h0005, 1'b0, 10'h39E);
    chk("override", cap, {1'b0, 16'h0005, 1'b0, 10'h30E});
    chk("ovr_side", side, 28'h0050505);
  endtask
  task automatic t_msi;
    bus(1'b1, `IPSA_REG_MSI_IDENT, 32'h5);
    req(4'h8, 32'h8000, 1'b0, 15'h0A80);
    chk("msi", cap, {1'b1, 16'h0005, 3'b101, 6'h2A, 2'b00});
    chk("msi_side", side, 28'h3008080);
  endtask
  task automatic t_kinds;
    for (int k = 0; k < 8; k++) begin
      req(4'(k), 32'h1000, 1'b0, 15'h0A80);
      chk("kind", {20'h0, cap[7:0]}, {20'h0, KTAB[k*8 +: 8]});
    end
  endtask
  task automatic t_stage2;
    req(4'h2, 32'h2000, 1'b0, {3'b100, 6'h17, 6'h0A});
    chk("s2_weaker", {20'h0, cap[7:0]}, 28'h28);
    req(4'h3, 32'h2000, 1'b0, {3'b111, 6'h17, 6'h0A});
    chk("s2_fwb_ptw", {20'h0, cap[7:0]}, 28'h58);
  endtask
  task automatic t_pcie;
    bus(1'b1, `IPSA_REG_PCIE_BASE, 32'h4000_0000);
    bus(1'b1, `IPSA_REG_PCIE_MASK, 32'hF000_0000);
    bus(1'b1, `IPSA_REG_CTRL, 32'h3);
    req(4'h0, 32'h4000_1000, 1'b0, 15'h0);
    chk("abort", 28'(ab), 28'h1);
    bus(1'b0, `IPSA_REG_STATUS, 32'h0);
    chk("fault", rd[27:0], 28'h00D0001);
    bus(1'b1, `IPSA_REG_STATUS, 32'h1);
    req(4'h3, 32'h4000_1000, 1'b1, 15'h0);
    chk("spec_abort", 28'(ab), 28'h1);
    bus(1'b0, `IPSA_REG_STATUS, 32'h0);
    chk("spec_fault", rd[27:0], 28'h00D0000);
    req(4'h6, 32'h4000_2000, 1'b0, 15'h0);
    chk("pcie_write", 28'(ab), 28'h0);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_client();
    t_override();
    t_msi();
    t_kinds();
    t_stage2();
    t_pcie();
    results();
  end
endmodule // ipsa_port_attr_tb
`default_nettype wire
